// ==== rtl/css_map.svh ====
// register offsets, field positions, reset values and timing counts
// for the slave-select serial channel; definitions only.
`ifndef CSS_MAP_SVH
`define CSS_MAP_SVH

`define CSS_IDX_DATA     4'h0
`define CSS_IDX_ALIAS    4'h1
`define CSS_IDX_MODE     4'h2
`define CSS_IDX_CTRL     4'h3
`define CSS_IDX_STATUS   4'h4
`define CSS_IDX_START    4'h5
`define CSS_IDX_STOP     4'h6
`define CSS_IDX_OE       4'h7
`define CSS_IDX_LEVEL    4'h8
`define CSS_IDX_ISW      4'h9
`define CSS_IDX_PER      4'hA
`define CSS_IDX_PSEL     4'hB

`define CSS_MODE_SRC     0
`define CSS_MODE_TX      1
`define CSS_MODE_RX      2
`define CSS_CTRL_DAP     0
`define CSS_CTRL_CKP     1
`define CSS_CTRL_LSB     2
`define CSS_CTRL_LEN7    3
`define CSS_STAT_OVF     0
`define CSS_STAT_BFF     1
`define CSS_STAT_BUSY    2
`define CSS_ISW_SSIE     7

`define CSS_MODE_RST     3'h2
`define CSS_CTRL_RST     4'h0
`define CSS_LEVEL_RST    1'b1
`define CSS_PSEL_RST     8'h00

`define CSS_LEN8         4'h8
`define CSS_LEN7         4'h7
`define CSS_PSEL_WAIT    3'h4
`define CSS_MIN_SCK_CLKS 6

`endif

// ==== rtl/css_pkg.sv ====
// types shared by the slave-select serial channel
// assumes nothing beyond a SystemVerilog compiler
package css_pkg;

	typedef enum logic [0:0] {
		CSS_IDLE   = 1'b0,
		CSS_ACTIVE = 1'b1
	} css_state_t;

	typedef logic [7:0] css_byte_t;

endpackage

// ==== rtl/css_sync.sv ====
// two-flop synchroniser for a group of pin inputs
// assumes the inputs are asynchronous to i_core_clk
`timescale 1ns/1ps
module css_sync #(
	parameter int W = 3
) (
	// clock and reset
	input  wire logic         i_core_clk,
	input  wire logic         i_rst_n,
	// pins in, synchronised out
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);

	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			always_ff @(posedge i_core_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					meta_reg[g] <= 1'b1;
					sync_reg[g] <= 1'b1;
				end else begin
					meta_reg[g] <= i_async[g];
					sync_reg[g] <= meta_reg[g];
				end
			end
		end
	endgenerate

	assign o_sync = sync_reg;

endmodule

// ==== rtl/css_top.sv ====
// slave-select clocked serial channel, slave side, channel zero
// assumes the master drives clock and select; registers reached over
// a plain strobe port with read data one cycle later
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "css_map.svh"
module css_top (
	// clock and reset
	input  wire logic        i_core_clk,
	input  wire logic        i_rst_n,
	// register port
	input  wire logic [3:0]  i_addr,
	input  wire logic [15:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [15:0] o_rdata,
	// serial pins
	input  wire logic        i_serial_clock_pin_ch0,
	input  wire logic        i_select_pin_ch0_n,
	input  wire logic        i_serial_in_pin_ch0,
	output logic             o_serial_out_pin_ch0,
	output logic             o_serial_out_oe,
	// channel event
	output logic             o_channel_event
);

	// reset release
	logic rst_meta_reg;
	logic rst_n;
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_meta_reg <= 1'b0;
			rst_n        <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n        <= rst_meta_reg;
		end
	end

	// pins pass two flops before use
	logic [2:0] pin_sync;
	css_sync #(
		.W(3)
	) u_sync (
		.i_core_clk (i_core_clk),
		.i_rst_n    (rst_n),
		.i_async    ({i_serial_in_pin_ch0, i_select_pin_ch0_n,
		              i_serial_clock_pin_ch0}),
		.o_sync     (pin_sync)
	);

	logic sck_s;
	logic ssi_n_s;
	logic si_s;
	assign sck_s   = pin_sync[0];
	assign ssi_n_s = pin_sync[1];
	assign si_s    = pin_sync[2];

	function automatic logic first_bit(input logic [7:0] sh,
	                                   input logic lsb,
	                                   input logic len7);
		first_bit = lsb ? sh[0] : (len7 ? sh[6] : sh[7]);
	endfunction

	// state
	css_pkg::css_state_t state_reg, state_next;
	css_pkg::css_byte_t  tx_buf_reg, tx_buf_next;
	css_pkg::css_byte_t  sh_reg, sh_next;
	css_pkg::css_byte_t  rx_sh_reg, rx_sh_next;
	css_pkg::css_byte_t  rx_data_reg, rx_data_next;
	logic [3:0]  cnt_reg, cnt_next;
	logic        tx_full_reg, tx_full_next;
	logic        rx_full_reg, rx_full_next;
	logic        ovf_reg, ovf_next;
	logic        run_reg, run_next;
	logic        unit_en_reg, unit_en_next;
	logic [2:0]  mode_reg, mode_next;
	logic [3:0]  ctrl_reg, ctrl_next;
	logic        oe_en_reg, oe_en_next;
	logic        so_reg, so_next;
	logic        ssie_reg, ssie_next;
	logic [7:0]  psel_reg, psel_next;
	logic [2:0]  pwait_reg, pwait_next;
	logic        sck_d_reg, sck_d_next;
	logic        pin_reg, pin_next;
	logic        pin_oe_reg, pin_oe_next;
	logic        evt_reg, evt_next;
	logic [15:0] rdata_reg, rdata_next;

	// working terms
	logic        dap, ckp, lsb, len7, src, tx_en, rx_only;
	logic        selected, active, eff, eff_d, rise, fall;
	logic        out_edge, in_edge;
	logic [3:0]  len;
	logic [7:0]  rx_shifted;

	always_comb begin
		dap      = ctrl_reg[`CSS_CTRL_DAP];
		ckp      = ctrl_reg[`CSS_CTRL_CKP];
		lsb      = ctrl_reg[`CSS_CTRL_LSB];
		len7     = ctrl_reg[`CSS_CTRL_LEN7];
		src      = mode_reg[`CSS_MODE_SRC];
		tx_en    = mode_reg[`CSS_MODE_TX];
		rx_only  = mode_reg[`CSS_MODE_RX] & ~tx_en;
		len      = len7 ? `CSS_LEN7 : `CSS_LEN8;
		selected = ~ssie_reg | ~ssi_n_s;
		active   = run_reg & unit_en_reg;
		eff      = sck_s ^ ckp;
		eff_d    = sck_d_reg ^ ckp;
		rise     = eff & ~eff_d;
		fall     = ~eff & eff_d;
		// phase 1 swaps the output and sampling edges
		out_edge = active & selected & (dap ? rise : fall);
		in_edge  = active & selected & (dap ? fall : rise);
		rx_shifted = lsb ? {si_s, rx_sh_reg[7:1]}
		                 : {rx_sh_reg[6:0], si_s};

		state_next   = state_reg;
		tx_buf_next  = tx_buf_reg;
		sh_next      = sh_reg;
		rx_sh_next   = rx_sh_reg;
		rx_data_next = rx_data_reg;
		cnt_next     = cnt_reg;
		tx_full_next = tx_full_reg;
		rx_full_next = rx_full_reg;
		ovf_next     = ovf_reg;
		run_next     = run_reg;
		unit_en_next = unit_en_reg;
		mode_next    = mode_reg;
		ctrl_next    = ctrl_reg;
		oe_en_next   = oe_en_reg;
		so_next      = so_reg;
		ssie_next    = ssie_reg;
		psel_next    = psel_reg;
		pwait_next   = pwait_reg;
		sck_d_next   = sck_s;
		evt_next     = 1'b0;
		rdata_next   = 16'h0000;

		// guard window after the unit is switched on
		if (!unit_en_reg)
			pwait_next = 3'h0;
		else if (pwait_reg != `CSS_PSEL_WAIT)
			pwait_next = pwait_reg + 3'h1;

		// reads; a data read frees the receive buffer
		if (i_rd) begin
			case (i_addr)
				`CSS_IDX_DATA,
				`CSS_IDX_ALIAS: begin
					rdata_next   = {8'h00, rx_data_reg};
					rx_full_next = 1'b0;
				end
				`CSS_IDX_MODE:   rdata_next = {13'h0000, mode_reg};
				`CSS_IDX_CTRL:   rdata_next = {12'h000, ctrl_reg};
				`CSS_IDX_STATUS: rdata_next = {13'h0000,
				                  state_reg == css_pkg::CSS_ACTIVE,
				                  tx_full_reg | rx_full_reg, ovf_reg};
				`CSS_IDX_START:  rdata_next = {15'h0000, run_reg};
				`CSS_IDX_OE:     rdata_next = {15'h0000, oe_en_reg};
				`CSS_IDX_LEVEL:  rdata_next = {15'h0000, so_reg};
				`CSS_IDX_ISW:    rdata_next = {8'h00, ssie_reg, 7'h00};
				`CSS_IDX_PER:    rdata_next = {15'h0000, unit_en_reg};
				`CSS_IDX_PSEL:   rdata_next = {8'h00, psel_reg};
				default:         rdata_next = 16'h0000;
			endcase
		end

		// shift engine; set of any flag lands after the clears above
		if (!active) begin
			state_next = css_pkg::CSS_IDLE;
			cnt_next   = 4'h0;
		end else begin
			// phase 1 presents the first bit without waiting for select
			if (dap && state_reg == css_pkg::CSS_IDLE &&
			    (tx_full_reg || !tx_en)) begin
				sh_next      = (tx_en && tx_full_reg) ? tx_buf_reg : 8'hFF;
				tx_full_next = 1'b0;
				so_next      = first_bit(sh_next, lsb, len7);
				state_next   = css_pkg::CSS_ACTIVE;
				cnt_next     = 4'h0;
				if (tx_en && src)
					evt_next = 1'b1;
			end
			if (out_edge) begin
				if (state_reg == css_pkg::CSS_IDLE && !dap) begin
					// transfer starts only on the master's clock
					sh_next      = (tx_en && tx_full_reg) ? tx_buf_reg
					                                      : 8'hFF;
					tx_full_next = tx_en ? 1'b0 : tx_full_reg;
					so_next      = first_bit(sh_next, lsb, len7);
					state_next   = css_pkg::CSS_ACTIVE;
					cnt_next     = 4'h0;
					if (tx_en && src)
						evt_next = 1'b1;
				end else if (state_reg == css_pkg::CSS_ACTIVE &&
				             cnt_reg != 4'h0) begin
					sh_next = lsb ? {1'b1, sh_reg[7:1]}
					              : {sh_reg[6:0], 1'b1};
					so_next = first_bit(sh_next, lsb, len7);
				end
			end
			if (in_edge && state_reg == css_pkg::CSS_ACTIVE) begin
				rx_sh_next = rx_shifted;
				cnt_next   = cnt_reg + 4'h1;
				if (cnt_reg + 4'h1 == len) begin
					state_next = css_pkg::CSS_IDLE;
					cnt_next   = 4'h0;
					if (len7)
						rx_data_next = lsb ? {1'b0, rx_shifted[7:1]}
						                   : {1'b0, rx_shifted[6:0]};
					else
						rx_data_next = rx_shifted;
					if (rx_full_reg && i_rd == 1'b0)
						ovf_next = 1'b1;
					else if (rx_full_reg && i_addr != `CSS_IDX_DATA &&
					         i_addr != `CSS_IDX_ALIAS)
						ovf_next = 1'b1;
					rx_full_next = 1'b1;
					// receive-only never uses the buffer-empty source
					if (rx_only || !src)
						evt_next = 1'b1;
				end
			end
		end

		// writes
		if (i_wr) begin
			case (i_addr)
				`CSS_IDX_DATA,
				`CSS_IDX_ALIAS: begin
					tx_buf_next  = i_wdata[7:0];
					tx_full_next = 1'b1;
				end
				`CSS_IDX_MODE:   mode_next = i_wdata[2:0];
				`CSS_IDX_CTRL:   ctrl_next = i_wdata[3:0];
				`CSS_IDX_STATUS: begin
					if (i_wdata[`CSS_STAT_OVF] && ovf_next == ovf_reg)
						ovf_next = 1'b0;
				end
				`CSS_IDX_START: begin
					if (i_wdata[0] && unit_en_reg)
						run_next = 1'b1;
				end
				`CSS_IDX_STOP: begin
					if (i_wdata[0])
						run_next = 1'b0;
				end
				`CSS_IDX_OE:    oe_en_next = i_wdata[0];
				`CSS_IDX_LEVEL: so_next    = i_wdata[0];
				`CSS_IDX_ISW:   ssie_next  = i_wdata[`CSS_ISW_SSIE];
				`CSS_IDX_PER: begin
					unit_en_next = i_wdata[0];
					if (!i_wdata[0])
						run_next = 1'b0;
				end
				`CSS_IDX_PSEL: begin
					if (unit_en_reg && pwait_reg == `CSS_PSEL_WAIT)
						psel_next = i_wdata[7:0];
				end
				default: ;
			endcase
		end

		// while running, deselected slaves release the shared line high, except that a
		// phase 1 byte already loaded shows its first bit ahead of select
		if (active && !selected &&
		    !(dap && state_reg == css_pkg::CSS_ACTIVE && cnt_reg == 4'h0))
			pin_next = 1'b1;
		else
			pin_next = so_reg;
		pin_oe_next = unit_en_reg & tx_en & oe_en_reg;
	end

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg   <= css_pkg::CSS_IDLE;
			tx_buf_reg  <= 8'h00;
			sh_reg      <= 8'hFF;
			rx_sh_reg   <= 8'h00;
			rx_data_reg <= 8'h00;
			cnt_reg     <= 4'h0;
			tx_full_reg <= 1'b0;
			rx_full_reg <= 1'b0;
			ovf_reg     <= 1'b0;
			run_reg     <= 1'b0;
			unit_en_reg <= 1'b0;
			mode_reg    <= `CSS_MODE_RST;
			ctrl_reg    <= `CSS_CTRL_RST;
			oe_en_reg   <= 1'b0;
			so_reg      <= `CSS_LEVEL_RST;
			ssie_reg    <= 1'b0;
			psel_reg    <= `CSS_PSEL_RST;
			pwait_reg   <= 3'h0;
			sck_d_reg   <= 1'b1;
			pin_reg     <= 1'b1;
			pin_oe_reg  <= 1'b0;
			evt_reg     <= 1'b0;
			rdata_reg   <= 16'h0000;
		end else begin
			state_reg   <= state_next;
			tx_buf_reg  <= tx_buf_next;
			sh_reg      <= sh_next;
			rx_sh_reg   <= rx_sh_next;
			rx_data_reg <= rx_data_next;
			cnt_reg     <= cnt_next;
			tx_full_reg <= tx_full_next;
			rx_full_reg <= rx_full_next;
			ovf_reg     <= ovf_next;
			run_reg     <= run_next;
			unit_en_reg <= unit_en_next;
			mode_reg    <= mode_next;
			ctrl_reg    <= ctrl_next;
			oe_en_reg   <= oe_en_next;
			so_reg      <= so_next;
			ssie_reg    <= ssie_next;
			psel_reg    <= psel_next;
			pwait_reg   <= pwait_next;
			sck_d_reg   <= sck_d_next;
			pin_reg     <= pin_next;
			pin_oe_reg  <= pin_oe_next;
			evt_reg     <= evt_next;
			rdata_reg   <= rdata_next;
		end
	end

	assign o_rdata              = rdata_reg;
	assign o_serial_out_pin_ch0 = pin_reg;
	assign o_serial_out_oe      = pin_oe_reg;
	assign o_channel_event      = evt_reg;

endmodule

// ==== sim/css_master_model.sv ====
// external serial master: drives clock, select and data to the slave
// assumes the bench resolves the pulled-up return line into i_miso
`timescale 1ns/1ps
module css_master_model (
	input  wire logic i_core_clk,
	input  wire logic i_miso,
	output logic      o_sck,
	output logic      o_ss_n,
	output logic      o_mosi
);
	// half period of eight clocks keeps well above the six-clock floor
	localparam int HALF = 8;
	initial begin
		o_sck = 1'b1;
		o_ss_n = 1'b1;
		o_mosi = 1'b0;
	end
	task automatic xfer(input logic ckp, input logic dap, input logic sel,
		input logic [7:0] tx, output logic [7:0] rx);
		rx = 8'h00;
		@(posedge i_core_clk);
		o_sck <= ~ckp;
		repeat (HALF) @(posedge i_core_clk);
		o_ss_n <= ~sel;
		if (dap) o_mosi <= tx[7];
		repeat (HALF) @(posedge i_core_clk);
		for (int i = 7; i >= 0; i--) begin
			if (dap) rx[i] = i_miso;
			o_sck <= ckp;
			if (!dap) o_mosi <= tx[i];
			repeat (HALF) @(posedge i_core_clk);
			if (!dap) rx[i] = i_miso;
			o_sck <= ~ckp;
			if (dap && i > 0) o_mosi <= tx[i-1];
			repeat (HALF) @(posedge i_core_clk);
		end
		o_ss_n <= 1'b1;
		// released line shows no stale bit
		o_mosi <= ~o_mosi;
	endtask
endmodule

// ==== sim/css_top_chk.sv ====
// checker on the serial channel top ports
// assumes register writes are seen here as the design sees them
`timescale 1ns/1ps
`include "css_map.svh"
module css_top_chk (
	input wire logic        i_core_clk,
	input wire logic        i_rst_n,
	input wire logic [3:0]  i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [15:0] o_rdata,
	input wire logic        i_serial_clock_pin_ch0,
	input wire logic        i_select_pin_ch0_n,
	input wire logic        o_serial_out_pin_ch0,
	input wire logic        o_serial_out_oe,
	input wire logic        o_channel_event
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	logic       unit_reg, tx_reg, ssie_reg, run_reg, sck_reg;
	logic [2:0] desel_reg, sckq_reg, quiet_reg;
	wire [15:0] hit = i_wr ? (16'h0001 << i_addr) : 16'h0000;
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			{unit_reg, ssie_reg, run_reg} <= 3'h0;
			{tx_reg, sck_reg} <= 2'h3;
			{desel_reg, sckq_reg, quiet_reg} <= 9'h038;
		end else begin
			if (hit[`CSS_IDX_PER]) unit_reg <= i_wdata[0];
			if (hit[`CSS_IDX_MODE]) tx_reg <= i_wdata[1];
			if (hit[`CSS_IDX_ISW]) ssie_reg <= i_wdata[7];
			if (hit[`CSS_IDX_START] && i_wdata[0] && unit_reg)
				run_reg <= 1'b1;
			if (hit[`CSS_IDX_STOP] && i_wdata[0])
				run_reg <= 1'b0;
			sck_reg <= i_serial_clock_pin_ch0;
			desel_reg <= !i_select_pin_ch0_n ? 3'h0
				: desel_reg + {2'h0, desel_reg != 3'h7};
			sckq_reg <= (i_serial_clock_pin_ch0 != sck_reg) ? 3'h0
				: sckq_reg + {2'h0, sckq_reg != 3'h7};
			quiet_reg <= (run_reg || hit[`CSS_IDX_LEVEL]) ? 3'h0
				: quiet_reg + {2'h0, quiet_reg != 3'h7};
		end
	end
	AST_NO_EVT_DESEL: assert property (
		ssie_reg && desel_reg == 3'h7 |-> !o_channel_event)
		else $error("event while deselected");
	AST_EVT_NEEDS_SCK: assert property (
		o_channel_event |-> sckq_reg < 3'h6)
		else $error("event without serial clock");
	AST_EVT_PULSE: assert property (
		o_channel_event |=> !o_channel_event)
		else $error("event longer than one cycle");
	AST_ALIAS_HIGH: assert property (
		$past(i_rd && i_addr == `CSS_IDX_ALIAS) |-> o_rdata[15:8] == 8'h00)
		else $error("alias upper byte set");
	AST_STATUS_BITS: assert property (
		$past(i_rd && i_addr == `CSS_IDX_STATUS) |-> o_rdata[15:3] == 13'h0)
		else $error("unexpected status flag");
	AST_OE_RXONLY: assert property (
		!tx_reg && !$past(tx_reg) |-> !o_serial_out_oe)
		else $error("output enabled in receive only");
	AST_OE_UNIT_OFF: assert property (
		!unit_reg && !$past(unit_reg) |-> !o_serial_out_oe)
		else $error("output enabled with unit off");
	AST_HOLD_STOPPED: assert property (
		quiet_reg == 3'h7 |-> $stable(o_serial_out_pin_ch0))
		else $error("stopped output moved");
	cover property (o_channel_event);
	cover property (o_serial_out_oe && !i_select_pin_ch0_n);
	cover property (run_reg ##1 !run_reg);
endmodule
bind css_top css_top_chk chk_u (.*);

// ==== sim/csi_slave_select_transceiver_bench.sv ====
// self-checking bench: register port stimulus plus a serial master
// assumes the register indices and fields of css_map.svh
`timescale 1ns/1ps
`include "css_map.svh"
module csi_slave_select_transceiver_bench;
	logic        i_core_clk, i_rst_n, i_wr, i_rd, so, oe, evt;
	logic        sck, ss_n, mosi;
	logic [3:0]  i_addr;
	logic [15:0] i_wdata, o_rdata;
	int          fail_count, cmp_count, evt_cnt, cyc, e0;
	// open-drain return toward the master, pulled up
	wire         line = oe ? so : 1'b1;
	css_top dut_u (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_serial_clock_pin_ch0(sck),
		.i_select_pin_ch0_n(ss_n), .i_serial_in_pin_ch0(mosi),
		.o_serial_out_pin_ch0(so), .o_serial_out_oe(oe),
		.o_channel_event(evt));
	css_master_model m_u (.i_core_clk(i_core_clk), .i_miso(line),
		.o_sck(sck), .o_ss_n(ss_n), .o_mosi(mosi));
	initial begin
		i_core_clk = 1'b0;
		forever #2.5 i_core_clk = ~i_core_clk;
	end
	always @(posedge i_core_clk) begin
		cyc <= cyc + 1;
		if (evt) evt_cnt <= evt_cnt + 1;
		if (cyc == 20000) begin
			fail_count++;
			test_done();
		end
	end
	function automatic logic [7:0] rev(input logic [7:0] b);
		for (int i = 0; i < 8; i++) rev[i] = b[7-i];
	endfunction
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		i_addr <= a;
		i_wdata <= v;
		i_wr <= 1'b1;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
		// one idle edge so a following write never re-drives the strobe
		@(posedge i_core_clk);
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] v);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1 v = o_rdata;
		@(posedge i_core_clk);
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic xf(input logic [2:0] c, input logic s,
		input logic [7:0] t, output logic [7:0] g);
		e0 = evt_cnt;
		m_u.xfer(c[1], c[0], s, t, g);
		repeat (4) @(posedge i_core_clk);
	endtask
	task automatic test_done();
		$display("checks %0d failures %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		logic [15:0] d;
		logic [7:0]  tx, rxb, g;
		logic [2:0]  c;
		logic        v;
		{i_rst_n, i_wr, i_rd} = 3'h0;
		i_addr = 4'h0;
		i_wdata = 16'h0000;
		{fail_count, cmp_count, evt_cnt, cyc, e0} = '0;
		void'($urandom(32'hFA55AC48));
		repeat (6) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		repeat (3) @(posedge i_core_clk);
		wr(`CSS_IDX_START, 16'h0001);
		rd(`CSS_IDX_START, d);
		chk(d, 16'h0000);
		wr(`CSS_IDX_PER, 16'h0001);
		wr(`CSS_IDX_PSEL, 16'h005A);
		rd(`CSS_IDX_PSEL, d);
		chk(d, 16'h0000);
		repeat (4) @(posedge i_core_clk);
		wr(`CSS_IDX_PSEL, 16'h005A);
		rd(`CSS_IDX_PSEL, d);
		chk(d, 16'h005A);
		wr(`CSS_IDX_ISW, 16'h0080);
		wr(`CSS_IDX_MODE, 16'h0006);
		// the return line is only driven with the output enable set
		wr(`CSS_IDX_OE, 16'h0001);
		wr(`CSS_IDX_START, 16'h0001);
		rd(`CSS_IDX_START, d);
		chk(d, 16'h0001);
		for (int k = 0; k < 8; k++) begin
			c = 3'(k);
			tx = 8'($urandom);
			rxb = 8'($urandom);
			wr(`CSS_IDX_CTRL, {13'h0000, c});
			if (!c[0]) wr(`CSS_IDX_DATA, {8'h00, ~tx});
			wr(`CSS_IDX_DATA, {8'h00, tx});
			repeat (4) @(posedge i_core_clk);
			v = !c[0] | (c[2] ? tx[0] : tx[7]);
			chk({15'h0000, line}, {15'h0000, v});
			xf(c, 1'b1, rxb, g);
			chk({8'h00, g}, {8'h00, c[2] ? rev(tx) : tx});
			chk(16'(evt_cnt - e0), 16'h0001);
			rd(`CSS_IDX_ALIAS, d);
			chk(d, {8'h00, c[2] ? rev(rxb) : rxb});
		end
		wr(`CSS_IDX_CTRL, 16'h0000);
		for (int k = 0; k < 2; k++) begin
			wr(`CSS_IDX_MODE, k ? 16'h0005 : 16'h0007);
			wr(`CSS_IDX_DATA, {8'h00, tx});
			xf(3'h0, 1'b1, rxb, g);
			chk(16'(evt_cnt - e0), 16'h0001);
			chk({15'h0000, oe}, {15'h0000, k == 0});
			rd(`CSS_IDX_ALIAS, d);
		end
		xf(3'h0, 1'b0, rxb, g);
		chk(16'(evt_cnt - e0), 16'h0000);
		wr(`CSS_IDX_ISW, 16'h0000);
		xf(3'h0, 1'b0, rxb, g);
		chk(16'(evt_cnt - e0), 16'h0001);
		rd(`CSS_IDX_ALIAS, d);
		chk(d, {8'h00, rxb});
		xf(3'h0, 1'b1, rxb, g);
		xf(3'h0, 1'b1, rxb, g);
		rd(`CSS_IDX_STATUS, d);
		chk(d & 16'h0001, 16'h0001);
		wr(`CSS_IDX_STATUS, 16'h0001);
		rd(`CSS_IDX_STATUS, d);
		chk(d & 16'h0001, 16'h0000);
		wr(`CSS_IDX_STOP, 16'h0001);
		rd(`CSS_IDX_START, d);
		chk(d, 16'h0000);
		v = so;
		xf(3'h0, 1'b1, rxb, g);
		chk({15'h0000, so}, {15'h0000, v});
		chk(16'(evt_cnt - e0), 16'h0000);
		wr(`CSS_IDX_LEVEL, 16'h0000);
		repeat (3) @(posedge i_core_clk);
		chk({15'h0000, so}, 16'h0000);
		wr(4'hF, 16'hFFFF);
		rd(4'hF, d);
		chk(d, 16'h0000);
		test_done();
	end
endmodule
